/* File: hdl/sensor_spi_slave_port.sv */
`timescale 1ns/1ps
`include "spi_port_cfg.svh"
module sensor_spi_slave_port
    import spi_port_pkg::*;
#(
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    // clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rst_b_in,
    // serial pins
    input  wire logic       cs_b_in,
    input  wire logic       sclk_in,
    input  wire logic       sdi_in,
    input  wire logic       sdio_in,
    output logic            sdo_out,
    output logic            sdo_oe_b_out,
    output logic            sdio_out,
    output logic            sdio_oe_b_out,
    // status
    output logic            two_wire_mode_out,
    output logic            three_wire_out,
    output logic            gap_ok_out
);
    localparam int WW = 14;

    logic [1:0] cs_sync_ff, sclk_sync_ff, sdi_sync_ff, sdio_sync_ff;
    logic       sclk_d_ff;
    logic       cs_b, sclk, rise, fall, din;

    port_state_e      state_ff, nxt_state;
    logic [2:0]       bit_ff, nxt_bit;
    logic [7:0]       shift_ff, nxt_shift;
    logic [7:0]       tx_ff, nxt_tx;
    logic             rd_ff, nxt_rd;
    logic             burst_ff, nxt_burst;
    logic [5:0]       ptr_ff, nxt_ptr;
    logic             dout_ff, nxt_dout;
    logic             drive_ff, nxt_drive;
    logic [7:0]       regs_ff [`REG_COUNT];
    logic [7:0]       gap_ff, nxt_gap;
    logic             two_wire_ff, cs_seen_ff;
    wr_item_s         wr_item;
    logic             wr_push, wr_ready, wr_valid;
    logic [WW-1:0]    wr_word;
    wr_item_s         wr_head;

    // two-flop synchronisers on every pin input
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cs_sync_ff   <= 2'h3;
            sclk_sync_ff <= 2'h3;
            sdi_sync_ff  <= 2'h0;
            sdio_sync_ff <= 2'h0;
            sclk_d_ff    <= 1'h1;
        end else begin
            cs_sync_ff   <= {cs_sync_ff[0], cs_b_in};
            sclk_sync_ff <= {sclk_sync_ff[0], sclk_in};
            sdi_sync_ff  <= {sdi_sync_ff[0], sdi_in};
            sdio_sync_ff <= {sdio_sync_ff[0], sdio_in};
            sclk_d_ff    <= sclk_sync_ff[1];
        end
    end

    always_comb begin
        cs_b = cs_sync_ff[1];
        sclk = sclk_sync_ff[1];
        rise = sclk && !sclk_d_ff && !cs_b;
        fall = !sclk && sclk_d_ff && !cs_b;
        din  = regs_ff[`OUT_FMT_ADDR][`OUT_FMT_3WIRE] ? sdio_sync_ff[1] : sdi_sync_ff[1];
    end

    // serial engine
    always_comb begin
        nxt_state = state_ff;
        nxt_bit   = bit_ff;
        nxt_shift = shift_ff;
        nxt_tx    = tx_ff;
        nxt_rd    = rd_ff;
        nxt_burst = burst_ff;
        nxt_ptr   = ptr_ff;
        nxt_dout  = dout_ff;
        nxt_drive = drive_ff;
        wr_push   = 1'b0;
        wr_item   = '{addr: ptr_ff, data: {shift_ff[6:0], din}};
        if (cs_b) begin
            nxt_state = ST_IDLE;
            nxt_drive = 1'b0;
            nxt_bit   = '0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    nxt_state = ST_CMD;
                    nxt_bit   = '0;
                end
                ST_CMD: begin
                    if (rise) begin
                        nxt_shift = {shift_ff[6:0], din};
                        nxt_bit   = bit_ff + 3'h1;
                        if (bit_ff == `BIT_CNT_LAST) begin
                            nxt_rd    = shift_ff[`CMD_RW_BIT-1];
                            nxt_burst = shift_ff[`CMD_BURST_BIT-1];
                            nxt_ptr   = {shift_ff[4:0], din};
                            nxt_tx    = regs_ff[{shift_ff[4:0], din}];
                            nxt_state = ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (fall) begin
                        // shift out on falling edge
                        nxt_dout  = tx_ff[7];
                        nxt_tx    = {tx_ff[6:0], 1'b0};
                        nxt_drive = rd_ff;
                    end
                    if (rise) begin
                        nxt_shift = {shift_ff[6:0], din};
                        nxt_bit   = bit_ff + 3'h1;
                        if (bit_ff == `BIT_CNT_LAST) begin
                            // a full fifo drops the byte; its drain is always ready, so it never fills
                            wr_push = !rd_ff && wr_ready;
                            if (burst_ff) begin
                                nxt_ptr = ptr_ff + 6'h1;
                                nxt_tx  = regs_ff[ptr_ff + 6'h1];
                            end else begin
                                // without the burst flag the pointer stays put
                                nxt_state = ST_DATA;
                                nxt_tx    = '0;
                            end
                        end
                    end
                end
                default: nxt_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_ff <= ST_IDLE;
            bit_ff   <= '0;
            shift_ff <= '0;
            tx_ff    <= '0;
            rd_ff    <= 1'b0;
            burst_ff <= 1'b0;
            ptr_ff   <= '0;
            dout_ff  <= 1'b0;
            drive_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            bit_ff   <= nxt_bit;
            shift_ff <= nxt_shift;
            tx_ff    <= nxt_tx;
            rd_ff    <= nxt_rd;
            burst_ff <= nxt_burst;
            ptr_ff   <= nxt_ptr;
            dout_ff  <= nxt_dout;
            drive_ff <= nxt_drive;
        end
    end

    // writes land in the register file through a small fifo
    spi_wr_fifo #(
        .WIDTH (WW),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .core_clk_in   (core_clk_in),
        .rst_b_in      (rst_b_in),
        .in_valid_in   (wr_push),
        .in_ready_out  (wr_ready),
        .in_data_in    (wr_item),
        .out_valid_out (wr_valid),
        .out_ready_in  (1'b1),
        .out_data_out  (wr_word)
    );

    always_comb begin
        wr_head = wr_word;
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < `REG_COUNT; i++) begin
                regs_ff[i] <= (i == `OUT_FMT_ADDR) ? `OUT_FMT_RESET : 8'h00;
            end
        end else if (wr_valid) begin
            regs_ff[wr_head.addr] <= wr_head.data;
        end
    end

    // chip-select gap and mode strap
    always_comb begin
        nxt_gap = cs_b ? ((gap_ff == 8'(`CS_GAP_CYC)) ? gap_ff : gap_ff + 8'h1) : 8'h00;
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            gap_ff      <= 8'(`CS_GAP_CYC);
            two_wire_ff <= 1'b0;
            cs_seen_ff  <= 1'b0;
        end else begin
            gap_ff      <= nxt_gap;
            cs_seen_ff  <= cs_seen_ff | !cs_b;
            two_wire_ff <= cs_b && !cs_seen_ff;
        end
    end

    // output pins, enables low while driving
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sdo_out           <= 1'b0;
            sdo_oe_b_out      <= 1'b1;
            sdio_out          <= 1'b0;
            sdio_oe_b_out     <= 1'b1;
            two_wire_mode_out <= 1'b0;
            three_wire_out    <= 1'b0;
            gap_ok_out        <= 1'b1;
        end else begin
            sdo_out           <= dout_ff;
            sdo_oe_b_out      <= !(drive_ff && !cs_b && !regs_ff[`OUT_FMT_ADDR][`OUT_FMT_3WIRE]);
            sdio_out          <= dout_ff;
            sdio_oe_b_out     <= !(drive_ff && !cs_b && regs_ff[`OUT_FMT_ADDR][`OUT_FMT_3WIRE]);
            two_wire_mode_out <= two_wire_ff;
            three_wire_out    <= regs_ff[`OUT_FMT_ADDR][`OUT_FMT_3WIRE];
            gap_ok_out        <= gap_ff == 8'(`CS_GAP_CYC);
        end
    end
endmodule

/* File: hdl/spi_port_cfg.svh */
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH

// register map
`define OUT_FMT_ADDR     6'h31
`define OUT_FMT_RESET    8'h00
`define OUT_FMT_3WIRE    6
// command byte layout
`define CMD_RW_BIT       7
`define CMD_BURST_BIT    6
`define REG_COUNT        64
`define REG_ADDR_W       6
// timing, bench clock 200 MHz
`define CORE_PERIOD_NS   5
`define CS_GAP_NS        150
`define CS_GAP_CYC       ((`CS_GAP_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`define BIT_CNT_LAST     3'h7
`define FIFO_DEPTH       8

`endif

/* File: hdl/spi_port_pkg.sv */
package spi_port_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CMD,
        ST_DATA
    } port_state_e;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] data;
    } wr_item_s;
endpackage

/* File: hdl/spi_wr_fifo.sv */
`timescale 1ns/1ps
module spi_wr_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             rst_b_in,
    // fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0]      wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic             do_wr, do_rd;

    always_comb begin
        in_ready_out  = (wp_ff - rp_ff) != (AW+1)'(DEPTH);
        out_valid_out = wp_ff != rp_ff;
        out_data_out  = mem_ff[rp_ff[AW-1:0]];
        do_wr         = in_valid_in && in_ready_out;
        do_rd         = out_valid_out && out_ready_in;
        nxt_wp        = wp_ff + (AW+1)'(do_wr);
        nxt_rp        = rp_ff + (AW+1)'(do_rd);
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
        end
    end

    // storage needs no reset
    always_ff @(posedge core_clk_in) begin
        if (do_wr) begin
            mem_ff[wp_ff[AW-1:0]] <= in_data_in;
        end
    end
endmodule

/* File: dv/spi_port_sva.sv */
`timescale 1ns/1ps
module spi_port_sva (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // pins and status
    input wire logic cs_b_in,
    input wire logic sclk_in,
    input wire logic sdo_out,
    input wire logic sdo_oe_b_out,
    input wire logic sdio_out,
    input wire logic sdio_oe_b_out,
    input wire logic two_wire_mode_out,
    input wire logic three_wire_out,
    input wire logic gap_ok_out
);
    logic [5:0] hi_cnt_ff;
    logic [5:0] nxt_hi_cnt;
    // saturates so a long idle never wraps under the gap figure
    always_comb begin
        nxt_hi_cnt = !cs_b_in ? 6'h00 : hi_cnt_ff + {5'h00, hi_cnt_ff != 6'h3f};
    end
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hi_cnt_ff <= 6'h00;
        end else begin
            hi_cnt_ff <= nxt_hi_cnt;
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);
    a_cs_release: assert property (
        $rose(cs_b_in) |-> ##[1:6] (sdo_oe_b_out && sdio_oe_b_out))
        else $error("driver on after deselect");
    a_idle_quiet: assert property (
        cs_b_in [*8] |-> sdo_oe_b_out && sdio_oe_b_out)
        else $error("driver on while deselected");
    a_sdio_mode: assert property (!sdio_oe_b_out |-> three_wire_out)
        else $error("shared line driven in four-wire mode");
    a_sdo_on_fall: assert property (
        !sdo_oe_b_out && $past(!sdo_oe_b_out) && $changed(sdo_out) |-> !sclk_in)
        else $error("sdo moved while clock high");
    a_sdio_on_fall: assert property (
        !sdio_oe_b_out && $past(!sdio_oe_b_out) && $changed(sdio_out) |-> !sclk_in)
        else $error("sdio moved while clock high");
    a_mode_follows: assert property (
        $fell(cs_b_in) |-> ##[1:5] !two_wire_mode_out)
        else $error("two-wire flag kept after select");
    a_fmt_in_frame: assert property (
        $changed(three_wire_out) |-> !cs_b_in && sclk_in)
        else $error("format bit moved outside a write");
    a_gap_rise: assert property ($rose(gap_ok_out) |-> hi_cnt_ff >= 6'h1e)
        else $error("gap flag early");
    a_gap_due: assert property (hi_cnt_ff == 6'h28 |-> gap_ok_out)
        else $error("gap flag late");
endmodule

bind sensor_spi_slave_port spi_port_sva chk_u (
    .core_clk_in, .rst_b_in, .cs_b_in, .sclk_in, .sdo_out, .sdo_oe_b_out,
    .sdio_out, .sdio_oe_b_out, .two_wire_mode_out, .three_wire_out, .gap_ok_out
);

/* File: dv/spi_host_model.sv */
`timescale 1ns/1ps
module spi_host_model (
    // bus pins
    output logic      cs_b_out,
    output logic      sclk_out,
    output logic      dat_out,
    input  wire logic miso_in,
    // timing reference
    input  wire logic clk_in
);
    initial begin
        cs_b_out = 1'b1;
        sclk_out = 1'b1;
        dat_out  = 1'b0;
    end
    task automatic open_f();
        @(posedge clk_in);
        #1 cs_b_out = 1'b0;
        #80;
    endtask
    // a released line toggles rather than holding its last bit
    task automatic xbyte(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk_out = 1'b0;
            dat_out  = drv ? tx[i] : ~dat_out;
            #80;
            sclk_out = 1'b1;
            rx[i]    = miso_in;
            #80;
        end
    endtask
    task automatic close_f();
        cs_b_out = 1'b1;
        #200;
    endtask
endmodule

/* File: dv/sensor_spi_slave_port_bench.sv */
`timescale 1ns/1ps
module sensor_spi_slave_port_bench;
    logic core_clk = 1'b0;
    logic rst_b    = 1'b0;
    int   checks   = 0;
    int   error_cnt = 0;
    wire  cs_b, sclk, h_dat, sdo, sdo_oe_b, sdio, sdio_oe_b, two_w, tw3, gap_ok;
    wire  sdio_w = sdio_oe_b ? h_dat : sdio;
    wire  miso   = tw3 ? sdio_w : (sdo_oe_b ? ~sdo : sdo);
    always #2.5 core_clk = ~core_clk;
    sensor_spi_slave_port dut_u (
        .core_clk_in(core_clk), .rst_b_in(rst_b), .cs_b_in(cs_b), .sclk_in(sclk),
        .sdi_in(h_dat), .sdio_in(sdio_w), .sdo_out(sdo), .sdo_oe_b_out(sdo_oe_b),
        .sdio_out(sdio), .sdio_oe_b_out(sdio_oe_b), .two_wire_mode_out(two_w),
        .three_wire_out(tw3), .gap_ok_out(gap_ok)
    );
    spi_host_model host_u (
        .cs_b_out(cs_b), .sclk_out(sclk), .dat_out(h_dat), .miso_in(miso),
        .clk_in(core_clk)
    );
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic rd, input logic bst, input logic [5:0] a,
                       inout logic [7:0] q[$]);
        logic [7:0] r;
        host_u.open_f();
        host_u.xbyte({rd, bst, a}, 1'b1, r);
        foreach (q[i]) begin
            host_u.xbyte(q[i], !rd, r);
            if (rd) q[i] = r;
        end
        host_u.close_f();
    endtask
    task automatic wr(input logic bst, input logic [5:0] a, input logic [7:0] d[$]);
        acc(1'b0, bst, a, d);
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e[$]);
        logic [7:0] q[$];
        q = e;
        acc(1'b1, 1'(e.size() > 1), a, q);
        foreach (e[i]) chk(q[i], e[i]);
    endtask
    task end_sim;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // about fifty microseconds of traffic, so three times that means a hang
    initial begin
        #150000;
        error_cnt++;
        end_sim;
    end
    initial begin
        logic [7:0] rx;
        repeat (12) @(posedge core_clk);
        #1 rst_b = 1'b1;
        repeat (40) @(posedge core_clk);
        chk(8'(two_w), 8'h01);
        chk(8'(gap_ok), 8'h01);
        chk(8'({sdo_oe_b, sdio_oe_b, tw3}), 8'h06);
        rd_chk(6'h31, '{8'h00});
        chk(8'(two_w), 8'h00);
        wr(1'b0, 6'h10, '{8'ha5});
        rd_chk(6'h10, '{8'ha5});
        wr(1'b1, 6'h20, '{8'h01, 8'h82, 8'hc3, 8'h7e});
        rd_chk(6'h20, '{8'h01, 8'h82, 8'hc3, 8'h7e});
        rd_chk(6'h21, '{8'h82});
        wr(1'b0, 6'h08, '{8'h11, 8'h22});
        rd_chk(6'h08, '{8'h22, 8'h00});
        wr(1'b0, 6'h31, '{8'h40});
        chk(8'(tw3), 8'h01);
        wr(1'b0, 6'h12, '{8'h5a});
        rd_chk(6'h11, '{8'h00, 8'h5a});
        chk(8'({sdo_oe_b, sdio_oe_b}), 8'h03);
        wr(1'b0, 6'h31, '{8'h00});
        chk(8'(tw3), 8'h00);
        rd_chk(6'h10, '{8'ha5});
        host_u.open_f();
        chk(8'(gap_ok), 8'h00);
        host_u.xbyte({2'b10, 6'h10}, 1'b1, rx);
        host_u.xbyte(8'h00, 1'b0, rx);
        host_u.close_f();
        chk(rx, 8'ha5);
        chk(8'(gap_ok), 8'h01);
        end_sim;
    end
endmodule
